//--- hw/dcs_spi_ctrl.sv
// Serial control port with daisy-chain channel forwarding
`timescale 1ns/1ps
`default_nettype none

module dcs_spi_ctrl (
    input  wire logic                          clk_i,       // 40 MHz core clock
    input  wire logic                          resetn_i,    // Sync reset, low
    input  wire logic                          sclk_i,      // Host serial clock
    input  wire logic                          cs_n_i,      // Chip select, low
    input  wire logic                          sdi_i,       // Serial data in
    output logic                               sdo_o,       // Serial data out
    output logic                               sdo_oe_o,    // Out enable
    output logic                               serial_pass_through_out_o, // To next
    output dcs_pkg::dcs_reg_req_t              reg_req_o,   // Register access
    input  wire logic [dcs_pkg::DCS_DATA_W-1:0] reg_rdata_i, // Read data
    output logic                               wide_mode_o  // 16-bit host seen
);

    // ==========================================================
    // State register and edge detection
    dcs_pkg::dcs_state_t q;
    dcs_pkg::dcs_state_t d;

    logic rise;
    logic fall;
    logic cs_low;
    logic cs_end;
    logic cid_ph;

    // Edges judged on synchronised copies only, never the first stage
    assign rise   = q.sclk_s & ~q.sclk_p;
    assign fall   = ~q.sclk_s & q.sclk_p;
    assign cs_low = ~q.csn_s;
    assign cs_end = q.csn_s & ~q.csn_p;
    // Channel bits sit in the second half of the control byte
    assign cid_ph = (q.st == dcs_pkg::DCS_ST_CTRL) & q.cnt[2];

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        d = q;
        // Two-stage synchronisers for the sclk, cs_n and sdi pins; resetn_i is used directly
        d.sclk_m = sclk_i;
        d.sclk_s = q.sclk_m;
        d.sclk_p = q.sclk_s;
        d.csn_m  = cs_n_i;
        d.csn_s  = q.csn_m;
        d.csn_p  = q.csn_s;
        d.sdi_m  = sdi_i;
        d.sdi_s  = q.sdi_m;
        d.req.wr = 1'b0;
        d.req.rd = 1'b0;

        // Serial borrow: invert while all lower channel bits were zero.
        // Held while the clock is high, since count and borrow step at the rise
        if (!q.sclk_s)
        begin
            d.thru = q.sdi_s ^ (cs_low & cid_ph & q.cid_zero
                                & ~q.broadcast_flag);
        end

        // Read data latched one cycle after the request
        if (q.req.rd)
        begin
            d.rdata = reg_rdata_i;
        end

        if (rise && cs_low)
        begin
            d.cnt = q.cnt + 3'h1;
            case (q.st)
                dcs_pkg::DCS_ST_CTRL:
                begin
                    case (q.cnt)
                        dcs_pkg::DCS_BIT_FIRST:
                        begin
                            d.broadcast_flag = q.sdi_s;
                            d.cid_zero       = 1'b1;
                        end
                        dcs_pkg::DCS_BIT_DIR:  d.rd     = q.sdi_s;
                        dcs_pkg::DCS_BIT_ONE:  d.fmt_ok = q.sdi_s;
                        dcs_pkg::DCS_BIT_ZERO: d.fmt_ok = q.fmt_ok & ~q.sdi_s;
                        default:
                        begin
                            // Any one bit in the field means not channel 0
                            if (q.sdi_s)
                            begin
                                d.cid_zero = 1'b0;
                            end
                        end
                    endcase
                    if (q.cnt == dcs_pkg::DCS_BIT_LAST)
                    begin
                        d.st  = dcs_pkg::DCS_ST_ADDR;
                        // Broadcast reads are refused to avoid output contention
                        d.hit = q.fmt_ok & (q.broadcast_flag ? ~q.rd
                                : (q.cid_zero & ~q.sdi_s));
                    end
                end
                dcs_pkg::DCS_ST_ADDR:
                begin
                    // Upper two address bits fall off the end
                    d.req.addr = {q.req.addr[dcs_pkg::DCS_ADDR_W-2:0],
                                  q.sdi_s};
                    if (q.cnt == dcs_pkg::DCS_BIT_LAST)
                    begin
                        d.st     = dcs_pkg::DCS_ST_DATA;
                        d.req.rd = q.hit & q.rd;
                    end
                end
                dcs_pkg::DCS_ST_DATA:
                begin
                    if (!q.rd)
                    begin
                        d.shift = {q.shift[dcs_pkg::DCS_DATA_W-2:0],
                                   q.sdi_s};
                    end
                    if (q.cnt == dcs_pkg::DCS_BIT_LAST)
                    begin
                        d.st        = dcs_pkg::DCS_ST_DUP;
                        d.req.wr    = q.hit & ~q.rd;
                        // Read data bytes leave the write word untouched
                        if (!q.rd)
                        begin
                            d.req.wdata = {q.shift[dcs_pkg::DCS_DATA_W-2:0],
                                           q.sdi_s};
                        end
                    end
                end
                dcs_pkg::DCS_ST_DUP:
                begin
                    // Clocks here mean a 16-bit host; input is dropped
                    d.wide = 1'b1;
                    if (q.cnt == dcs_pkg::DCS_BIT_LAST)
                    begin
                        d.st  = dcs_pkg::DCS_ST_CTRL;
                        d.hit = 1'b0;
                    end
                end
                default:
                begin
                    d.st = dcs_pkg::DCS_ST_CTRL;
                end
            endcase
        end

        // Select released: a byte boundary keeps progress, else restart
        if (cs_end)
        begin
            if (q.cnt != 3'h0)
            begin
                d.st  = dcs_pkg::DCS_ST_CTRL;
                d.cnt = 3'h0;
                d.hit = 1'b0;
            end
            else if (q.st == dcs_pkg::DCS_ST_DUP)
            begin
                // Single data byte ends the 8-bit operation
                d.st   = dcs_pkg::DCS_ST_CTRL;
                d.hit  = 1'b0;
                d.wide = 1'b0;
            end
        end

        // Output shifts on falling clock, same byte twice in 16-bit mode
        if (fall)
        begin
            d.sdo = q.rdata[3'h7 - q.cnt];
        end

        // Only the addressed read target drives, and only in data bytes
        d.sdo_oe = cs_low & q.hit & q.rd
                   & ((q.st == dcs_pkg::DCS_ST_DATA)
                   | (q.st == dcs_pkg::DCS_ST_DUP));
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            q <= dcs_pkg::DCS_STATE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign sdo_o                     = q.sdo;
    assign sdo_oe_o                  = q.sdo_oe;
    assign serial_pass_through_out_o = q.thru;
    assign reg_req_o                 = q.req;
    assign wide_mode_o               = q.wide;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // Driving implies a non-broadcast read target; enable lags state a cycle
    oe_only_read_a: assert property (
        sdo_oe_o |-> ($past(q.rd) && $past(q.hit) && !$past(q.broadcast_flag)))
        else $error("output driven outside a targeted read");

    // Broadcast passes the channel bits unchanged
    bcast_pass_a: assert property (
        (q.broadcast_flag && cs_low && cid_ph)
        |=> (serial_pass_through_out_o == $past(q.sdi_s)))
        else $error("broadcast control bit altered");

    // Channel bits under borrow come out inverted
    cid_dec_a: assert property (
        (cs_low && cid_ph && q.cid_zero && !q.broadcast_flag && !q.sclk_s)
        |=> (serial_pass_through_out_o != $past(q.sdi_s)))
        else $error("channel field not decremented");

    // Write strobe only for write operations
    wr_dir_a: assert property (
        reg_req_o.wr |-> (!q.rd && q.st == dcs_pkg::DCS_ST_DUP))
        else $error("write strobe in wrong phase");

    // Write strobe is single-cycle
    wr_pulse_a: assert property (
        reg_req_o.wr |=> !reg_req_o.wr)
        else $error("write strobe longer than a cycle");

    // Read request marks start of the data byte
    rd_phase_a: assert property (
        reg_req_o.rd |-> (q.st == dcs_pkg::DCS_ST_DATA
                          && q.cnt == 3'h0 && q.rd))
        else $error("read request in wrong phase");

    // Mid-byte release returns to the control phase
    abort_idle_a: assert property (
        (cs_end && q.cnt != 3'h0)
        |=> (q.st == dcs_pkg::DCS_ST_CTRL && q.cnt == 3'h0 && !q.hit))
        else $error("mid-byte release not restarting");

    // Repeated byte is still driven in the second half
    dup_drive_a: assert property (
        (q.st == dcs_pkg::DCS_ST_DUP && q.rd && q.hit && cs_low)
        |=> sdo_oe_o)
        else $error("read byte not repeated");

    // Second word clocks flag the 16-bit host
    wide_seen_a: assert property (
        (rise && cs_low && q.st == dcs_pkg::DCS_ST_DUP)
        |=> wide_mode_o)
        else $error("16-bit host not detected");

    // Strobes come only from the addressed device
    strobe_hit_a: assert property (
        (reg_req_o.wr || reg_req_o.rd) |-> q.hit)
        else $error("strobe without a target match");

    // Malformed control bytes never reach the register file
    fmt_gate_a: assert property (
        (reg_req_o.wr || reg_req_o.rd) |-> q.fmt_ok)
        else $error("strobe after malformed control byte");

    // A broadcast can only ever write
    bcast_no_read_a: assert property (
        reg_req_o.rd |-> !q.broadcast_flag)
        else $error("read request during broadcast");

    // Input bits during a read data byte change nothing
    rd_sdi_ignored_a: assert property (
        (rise && cs_low && q.st == dcs_pkg::DCS_ST_DATA && q.rd)
        |=> ($stable(q.shift) && $stable(reg_req_o.wdata)))
        else $error("input used during read data byte");

    // Second half of a 16-bit write is thrown away
    wide_drop_a: assert property (
        (rise && cs_low && q.st == dcs_pkg::DCS_ST_DUP)
        |=> (!reg_req_o.wr && $stable(reg_req_o.wdata)))
        else $error("second write byte not discarded");

    // Released select releases the output next cycle
    oe_cs_a: assert property (
        !cs_low |=> !sdo_oe_o)
        else $error("output driven while deselected");

    // Outside the channel field the input is copied as is
    thru_plain_a: assert property (
        (!cid_ph && !q.sclk_s)
        |=> (serial_pass_through_out_o == $past(q.sdi_s)))
        else $error("pass-through bit altered");

    wr_done_c:  cover property (reg_req_o.wr);
    rd_done_c:  cover property (reg_req_o.rd ##[1:400] sdo_oe_o);
    wide_c:     cover property ($rose(wide_mode_o));
    abort_c:    cover property (cs_end && q.cnt != 3'h0);
    bcast_c:    cover property (reg_req_o.wr && q.broadcast_flag);

endmodule

`default_nettype wire

//--- hw/dcs_pkg.sv
// Constants and types for the daisy-chained serial control port
package dcs_pkg;

    // ==========================================================
    // Control byte layout
    localparam int unsigned DCS_BCAST_BIT  = 7;
    localparam int unsigned DCS_DIR_BIT    = 6;
    localparam int unsigned DCS_ONE_BIT    = 5;
    localparam int unsigned DCS_ZERO_BIT   = 4;
    localparam int unsigned DCS_CID_W      = 4;
    localparam int unsigned DCS_CHAN_LAST  = 15;

    // ==========================================================
    // Widths and bit positions within a byte
    localparam int unsigned DCS_ADDR_W     = 6;
    localparam int unsigned DCS_DATA_W     = 8;
    localparam logic [2:0]  DCS_BIT_FIRST  = 3'h0;
    localparam logic [2:0]  DCS_BIT_DIR    = 3'h1;
    localparam logic [2:0]  DCS_BIT_ONE    = 3'h2;
    localparam logic [2:0]  DCS_BIT_ZERO   = 3'h3;
    localparam logic [2:0]  DCS_BIT_LAST   = 3'h7;

    // ==========================================================
    // Byte phases of one operation
    typedef enum logic [1:0] {
        DCS_ST_CTRL,
        DCS_ST_ADDR,
        DCS_ST_DATA,
        DCS_ST_DUP
    } dcs_phase_t;

    // Register access toward the device core
    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [DCS_ADDR_W-1:0] addr;
        logic [DCS_DATA_W-1:0] wdata;
    } dcs_reg_req_t;

    // Whole state of the serial port
    typedef struct packed {
        logic                  sclk_m;
        logic                  sclk_s;
        logic                  sclk_p;
        logic                  csn_m;
        logic                  csn_s;
        logic                  csn_p;
        logic                  sdi_m;
        logic                  sdi_s;
        dcs_phase_t            st;
        logic [2:0]            cnt;
        logic                  broadcast_flag;
        logic                  rd;
        logic                  fmt_ok;
        logic                  cid_zero;
        logic                  hit;
        logic [DCS_DATA_W-1:0] shift;
        logic [DCS_DATA_W-1:0] rdata;
        logic                  sdo;
        logic                  sdo_oe;
        logic                  thru;
        logic                  wide;
        dcs_reg_req_t          req;
    } dcs_state_t;

    localparam dcs_state_t DCS_STATE_RST = '0;

endpackage

//--- sim/dcs_host_model.sv
// Host serial controller model for the chained control port
`timescale 1ns/1ps
`default_nettype none

module dcs_host_model (
    input  wire logic clk_i,    // Core clock for pacing
    input  wire logic sdo_i,    // Device read data
    input  wire logic sdo_oe_i, // Device drive enable
    input  wire logic thru_i,   // Pass-through from device
    output logic      sclk_o,   // Serial clock, idle low
    output logic      cs_n_o,   // Chip select, low
    output logic      sdi_o     // Serial data to device
);
    // ==========================================
    // Idle bus at time zero
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // ==========================================
    // Up to one byte, MSB first; 200 ns bit period, changes on falling core edges
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] rx, output logic [7:0] th);
        rx = 8'h00;
        th = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            sdi_o = tx[i];
            repeat (4) @(negedge clk_i);
            rx[i] = sdo_oe_i ? sdo_i : 1'bx; // Released line never matches
            th[i] = thru_i;
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
        end
    endtask

    // Whole operation; nl cuts the final byte short to force a resync
    task automatic op(input logic [7:0] c, a, d, input logic w, input int nl,
                      output logic [7:0] r1, r2, tc, ta);
        logic [7:0] b[4];
        logic [7:0] rx[4];
        logic [7:0] th[4];
        b = '{c, a, d, ~d};
        rx[3] = 8'h00;
        cs_n_o = 1'b0;
        for (int k = 0; k < (w ? 4 : 3); k++)
        begin
            if (k > 0 && !w)
            begin
                cs_n_o = 1'b1;
                sdi_o = ~sdi_o;
                repeat (8) @(negedge clk_i);
                cs_n_o = 1'b0;
            end
            repeat (4) @(negedge clk_i);
            xfer(b[k], (k == (w ? 3 : 2)) ? nl : 8, rx[k], th[k]);
        end
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        repeat (16) @(negedge clk_i);
        tc = th[0];
        ta = th[1];
        r1 = rx[2];
        r2 = rx[3];
    endtask
endmodule

`default_nettype wire

//--- sim/tb_daisy_chain_spi_control.sv
// Self-checking bench for the daisy-chained serial control port
`timescale 1ns/1ps
`default_nettype none

module tb_daisy_chain_spi_control;
    typedef struct { logic [7:0] c, a, d, rv; logic w, ew, er; } dcs_row_t;
    logic                 clk_i = 1'b0;
    logic                 resetn_i = 1'b0;
    logic                 sclk, cs_n, sdi, sdo, sdo_oe, thru, wide;
    dcs_pkg::dcs_reg_req_t req;
    logic [7:0]           rdata = 8'h00;
    logic [dcs_pkg::DCS_ADDR_W-1:0] wa;
    logic [7:0]           wd, r1, r2, tc, ta;
    int                   wr_n, rd_n, oe_n, bad_count, n_tests;
    // Control, address, data, read value, 16-bit, write seen, read seen
    dcs_row_t t[10] = '{
        '{8'h20, 8'hC5, 8'h3C, 8'h00, 0, 1, 0}, '{8'h60, 8'h12, 8'h77, 8'h96, 0, 0, 1},
        '{8'h20, 8'h3F, 8'hA7, 8'h00, 1, 1, 0}, '{8'h60, 8'h2A, 8'h00, 8'h4B, 1, 0, 1},
        '{8'h2C, 8'h01, 8'h55, 8'h00, 0, 0, 0}, '{8'hAA, 8'h07, 8'hC3, 8'h00, 1, 1, 0},
        '{8'hE0, 8'h08, 8'h00, 8'h5A, 0, 0, 0}, '{8'h30, 8'h09, 8'h11, 8'h00, 0, 0, 0},
        '{8'h00, 8'h0A, 8'h22, 8'h00, 0, 0, 0}, '{8'h7F, 8'h0B, 8'h00, 8'hF0, 0, 0, 0}};

    always #12.5 clk_i = ~clk_i;

    dcs_spi_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .serial_pass_through_out_o(thru),
        .reg_req_o(req), .reg_rdata_i(rdata), .wide_mode_o(wide));
    dcs_host_model host (.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .thru_i(thru),
        .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

    // ==========================================
    // Strobe and drive tallies, cleared by the sequence before each table operation and before the abort case
    always @(negedge clk_i)
    begin
        oe_n += sdo_oe;
        rd_n += req.rd;
        if (req.wr)
        begin
            wr_n++;
            wa = req.addr;
            wd = req.wdata;
        end
    end

    // Channel field is LSB first, so the decrement runs on reversed bits
    function automatic logic [7:0] fwd(input logic [7:0] c);
        logic [3:0] id;
        id = {c[0], c[1], c[2], c[3]} - 4'h1;
        return c[7] ? c : {c[7:4], id[0], id[1], id[2], id[3]};
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, s);
        n_tests++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        print_verdict();
    end

    // Table of operations, then reset and resync cases
    initial
    begin
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (8) @(negedge clk_i);
        for (int i = 0; i < 10; i++)
        begin
            rdata = t[i].rv;
            {wr_n, rd_n, oe_n} = '0;
            host.op(t[i].c, t[i].a, t[i].d, t[i].w, 8, r1, r2, tc, ta);
            if (t[i].c[5:4] == 2'b10) chk("thru_ctrl", fwd(t[i].c), tc);
            chk("thru_addr", t[i].a, ta);
            chk("wr_count", {7'h00, t[i].ew}, wr_n[7:0]);
            chk("rd_count", {7'h00, t[i].er}, rd_n[7:0]);
            chk("drive", {7'h00, t[i].er}, {7'h00, oe_n != 0});
            if (t[i].ew) chk("addr", {2'b00, t[i].a[5:0]}, {2'b00, wa});
            if (t[i].ew) chk("wdata", t[i].d, wd);
            if (t[i].er) chk("rdata", t[i].rv, r1);
            if (t[i].er) chk("rd_sdi", wd, req.wdata);
            if (t[i].er && t[i].w) chk("rdata2", t[i].rv, r2);
            if (t[i].ew || t[i].er) chk("wide", {7'h00, t[i].w}, {7'h00, wide});
        end
        resetn_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("reset", 8'h00, {3'h0, sdo_oe, thru, wide, req.wr, req.rd});
        resetn_i = 1'b1;
        repeat (8) @(negedge clk_i);
        {wr_n, rd_n, oe_n} = '0;
        host.op(8'h20, 8'h11, 8'h99, 0, 4, r1, r2, tc, ta);
        chk("abort_wr", 8'h00, wr_n[7:0]);
        host.op(8'h20, 8'h2E, 8'h5C, 0, 8, r1, r2, tc, ta);
        chk("resync_wr", 8'h01, wr_n[7:0]);
        chk("resync_wdata", 8'h5C, wd);
        print_verdict();
    end
endmodule

`default_nettype wire
